/* tb/hbmx_periph.sv */
`timescale 1ns/100ps
`default_nettype none
// external address latch plus a byte peripheral on the shared lines
module hbmx_periph
(
  input  wire logic        clk,
  input  wire logic [7:0]  dout,
  input  wire logic [7:0]  doe,
  input  wire logic [27:8] addr_hi,
  input  wire logic        ale,
  input  wire logic        rd_b,
  input  wire logic        wr_b,
  input  wire logic [3:0]  sel_b,
  output logic [7:0]       din,
  output logic [27:0]      acc_addr,
  output logic [7:0]       acc_data,
  output logic             acc_wr,
  output logic [3:0]       acc_sel,
  output logic             acc_ale
);
  logic [7:0] lat   = 8'h00; // latched low address
  logic [7:0] last  = 8'h00; // toggles when released so stale data never looks valid
  logic       aflag = 1'b0;  // ale seen in this access
  logic [7:0] rv;            // read byte, a function of the address
  assign rv = (aflag ? lat : 8'h00) ^ addr_hi[15:8] ^ 8'h5A;
  // resolved wire: device where it drives, else the peripheral
  assign din = (doe & dout) | (~doe & (!rd_b ? rv : last));
  // latch follows the lines during ale and holds into the data phase
  always_ff @(posedge clk)
  begin
    last <= !rd_b ? ~rv : ~last;
    if (ale)
    begin
      lat   <= din;
      aflag <= 1'b1;
    end
    else if (!(rd_b && wr_b))
    begin
      acc_addr <= {addr_hi, aflag ? lat : 8'h00};
      acc_wr   <= !wr_b;
      acc_data <= din;
      acc_sel  <= sel_b;
      acc_ale  <= aflag;
    end
    else
      aflag <= 1'b0;
  end
endmodule : hbmx_periph
`default_nettype wire

/* tb/hbmx_port_checker.sv */
`timescale 1ns/100ps
`default_nettype none
// pin-level checker for the muxed host-bus port
module hbmx_port_checker
(
  input wire logic       core_clk,
  input wire logic       rst_b,
  input wire logic [1:0] select_line_config,
  input wire logic       enabled,
  input wire logic       rsp_valid,
  input wire logic [7:0] shared_addr_data_oe,
  input wire logic       ale,
  input wire logic       rd_b,
  input wire logic       wr_b,
  input wire logic [3:0] sel_b
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  //////////////////////////////////////////////////////////////////////////////
  a_ale_owns_lines: assert property (ale |-> shared_addr_data_oe == 8'hFF) else $error("lines not driven in ale");
  a_ale_two_wide: assert property ($rose(ale) |-> ale [*2] ##1 !ale) else $error("ale width wrong");
  a_strobes_apart: assert property ((rd_b || wr_b) && (ale -> rd_b && wr_b)) else $error("strobe overlap");
  a_read_releases: assert property (!rd_b |-> shared_addr_data_oe == 8'h00) else $error("lines driven in read");
  a_write_drives: assert property (!wr_b |-> shared_addr_data_oe == 8'hFF) else $error("lines idle in write");
  a_strobe_span: assert property ($fell(rd_b && wr_b) |-> !(rd_b && wr_b) [*3] ##1 (rd_b && wr_b && rsp_valid))
    else $error("strobe length or answer wrong");
  a_latch_first: assert property ($fell(rd_b && wr_b) && select_line_config[0] == select_line_config[1] |-> $past(ale))
    else $error("no ale before strobe");
  a_select_set: assert property (sel_b[3:2] == 2'b11 && (select_line_config != 2'h0 || sel_b == 4'hF)
    && (select_line_config != 2'h1 || sel_b[1])) else $error("select pattern wrong");
  a_no_ale_cfg: assert property (select_line_config inside {2'h1, 2'h2} |-> !ale) else $error("ale in select-only");
  a_off_quiet: assert property (!enabled |-> rd_b && wr_b) else $error("strobe while inactive");
  a_sel_no_hop: assert property (!$stable(sel_b) |-> sel_b == 4'hF || $past(sel_b) == 4'hF)
    else $error("select changed inside access");
  // main scenarios reached
  c_read: cover property ($fell(rd_b));
  c_write: cover property ($fell(wr_b));
  c_ale_two_sel: cover property ($rose(ale) && select_line_config == 2'h3);
endmodule : hbmx_port_checker
bind hbmx_port hbmx_port_checker u_chk (.core_clk, .rst_b, .select_line_config, .enabled, .rsp_valid,
  .shared_addr_data_oe, .ale, .rd_b, .wr_b, .sel_b);
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/100ps
`default_nettype none
// self-checking bench for the muxed host-bus port
module tb;
  import hbmx_pkg::*;
  logic        core_clk  = 1'b0;
  logic        rst_b     = 1'b0;
  logic [3:0]  main_cfg  = HBMX_MAIN_MODE_HB8;
  logic [1:0]  hb_cfg    = HBMX_HB_MODE_MUX;
  logic [1:0]  cs_cfg    = HBMX_CS_ALE;
  logic        req_valid = 1'b0;
  logic        req_write = 1'b0;
  logic [27:0] req_addr  = 28'h0;
  logic [7:0]  req_wdata = 8'h00;
  logic        req_ready, rsp_valid, enabled, ale, rd_b, wr_b, acc_wr, acc_ale, ale_cfg;
  logic [7:0]  rsp_rdata, dout, doe, din, acc_data;
  logic [27:8] addr_hi;
  logic [27:0] acc_addr;
  logic [3:0]  sel_b, acc_sel;
  logic [36:0] e;
  logic [36:0] exp_q[$]; // {write, address, data} in issue order
  int          n_fail    = 0;
  int          checked   = 0;
  assign ale_cfg = cs_cfg == HBMX_CS_ALE || cs_cfg == HBMX_CS_ALE_TWO;
  always #2 core_clk = ~core_clk;
  //////////////////////////////////////////////////////////////////////////////
  hbmx_port uut (.core_clk, .rst_b, .interface_main_config(main_cfg), .host_bus_config(hb_cfg),
    .select_line_config(cs_cfg), .req_valid, .req_ready, .req_write, .req_addr, .req_wdata, .rsp_valid,
    .rsp_rdata, .shared_addr_data_out(dout), .shared_addr_data_oe(doe), .shared_addr_data_in(din),
    .addr_hi, .ale, .rd_b, .wr_b, .sel_b, .enabled);
  hbmx_periph u_periph (.clk(core_clk), .dout, .doe, .addr_hi, .ale, .rd_b, .wr_b, .sel_b, .din,
    .acc_addr, .acc_data, .acc_wr, .acc_sel, .acc_ale);
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [35:0] s, input logic [35:0] x);
    checked++;
    if (s !== x)
    begin
      n_fail++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, s, x);
    end
  endtask : chk
  task automatic summarize;
    if (n_fail == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize
  // holds the request until the edge that takes it; valid stays up for back-to-back use
  task automatic send(input logic w, input logic [27:0] a, input logic [7:0] d);
    int n;
    n = 0;
    req_valid = 1'b1;
    req_write = w;
    req_addr  = a;
    req_wdata = d;
    while (req_ready !== 1'b1 && n < 100)
    begin
      @(negedge core_clk);
      n++;
    end
    chk(n < 100, 1'b1);
    exp_q.push_back({w, a, d});
    @(negedge core_clk);
  endtask : send
  task automatic drain;
    int n;
    n = 0;
    req_valid = 1'b0;
    while (exp_q.size() != 0 && n < 200)
    begin
      @(negedge core_clk);
      n++;
    end
    chk(exp_q.size(), 0);
  endtask : drain
  function automatic logic [3:0] exp_sel(input logic [27:0] a);
    return cs_cfg == HBMX_CS_ALE ? 4'hF : cs_cfg == HBMX_CS_ONE ? 4'hE : a[27] ? 4'hD : 4'hE;
  endfunction : exp_sel
  // each answer is compared with what the peripheral saw on its pins
  always @(negedge core_clk)
    if (rsp_valid === 1'b1)
    begin
      e = exp_q.size() ? exp_q.pop_front() : 37'h0;
      chk(acc_addr, {e[35:16], {8{ale_cfg}} & e[15:8]});
      chk(acc_wr, e[36]);
      chk(e[36] ? acc_data : rsp_rdata, e[36] ? e[7:0] : ({8{ale_cfg}} & e[15:8]) ^ e[23:16] ^ 8'h5A);
      chk(acc_sel, exp_sel(e[35:8]));
      chk(acc_ale, ale_cfg);
    end
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h29F40B36));
    repeat (16) @(negedge core_clk);
    rst_b = 1'b1;
    repeat (3) @(negedge core_clk);
    for (int c = 0; c < 4; c++)
    begin
      cs_cfg = 2'(c);
      send(1'b1, 28'hFFFFFFF, 8'hFF);
      send(1'b0, 28'hFFFFFFF, 8'h00);
      send(1'b0, 28'h0000000, 8'h00);
      repeat (12) send(1'($urandom), 28'($urandom), 8'($urandom));
      drain();
    end
    // inactive personality: requests wait in the buffer until enabled
    main_cfg = 4'h0;
    repeat (3) @(negedge core_clk);
    send(1'b1, 28'h8123456, 8'hA5);
    send(1'b0, 28'h0ABCDEF, 8'h00);
    req_valid = 1'b0;
    chk(req_ready, 1'b0);
    main_cfg = HBMX_MAIN_MODE_HB8;
    hb_cfg = 2'h1;
    repeat (20) @(negedge core_clk);
    chk(exp_q.size(), 2);
    hb_cfg = HBMX_HB_MODE_MUX;
    drain();
    for (int i = 0; i < 16; i++)
    begin
      {main_cfg, hb_cfg} = 6'(i);
      repeat (4) @(negedge core_clk);
      chk(enabled, main_cfg == HBMX_MAIN_MODE_HB8 && hb_cfg == HBMX_HB_MODE_MUX);
    end
    summarize();
  end
  // cut a hang short
  initial
  begin
    #40000;
    n_fail++;
    summarize();
  end
endmodule : tb
`default_nettype wire

/* verilog/hbmx_buf.sv */
`timescale 1ns/100ps
`default_nettype none
// two-entry buffer; read data come from registers
module hbmx_buf
#(
  parameter int W = 8
)
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic [W-1:0] slot0;   // head entry
  logic [W-1:0] slot1;   // second entry
  logic [1:0]   count;   // entries held
  logic         push;
  logic         pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign in_ready  = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data  = slot0;

  ////////////////////////////////////////////////////////////////
  // occupancy
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      count <= 2'h0;
    else
      count <= 2'(count + {1'b0, push} - {1'b0, pop});
  end

  // storage; head refilled from slot1 or input on pop
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      slot0 <= '0;
      slot1 <= '0;
    end
    else
    begin
      if (pop)
      begin
        slot0 <= (count == 2'h2) ? slot1 : in_data;
        if (push && count == 2'h2)
          slot1 <= in_data;
      end
      else if (push)
      begin
        if (count == 2'h0)
          slot0 <= in_data;
        else
          slot1 <= in_data;
      end
    end
  end
endmodule : hbmx_buf
`default_nettype wire

/* verilog/hbmx_pkg.sv */
`default_nettype none
package hbmx_pkg;
  // main mode field: host-bus personality code
  localparam int         HBMX_MAIN_MODE_W   = 4;
  localparam logic [3:0] HBMX_MAIN_MODE_HB8 = 4'h2;
  // host-bus mode field: multiplexed variant
  localparam logic [1:0] HBMX_HB_MODE_MUX   = 2'h0;
  // select-line configuration codes
  localparam logic [1:0] HBMX_CS_ALE        = 2'h0;
  localparam logic [1:0] HBMX_CS_ONE        = 2'h1;
  localparam logic [1:0] HBMX_CS_TWO        = 2'h2;
  localparam logic [1:0] HBMX_CS_ALE_TWO    = 2'h3;
  // widths
  localparam int         HBMX_DW            = 8;
  localparam int         HBMX_AW            = 28;
  // phase lengths in ns and derived cycles at 250 MHz
  localparam int         HBMX_CLK_PS        = 4000;
  localparam int         HBMX_ALE_NS        = 8;
  localparam int         HBMX_STB_NS        = 12;
  localparam int         HBMX_ALE_CYC       = (HBMX_ALE_NS * 1000 + HBMX_CLK_PS - 1) / HBMX_CLK_PS;
  localparam int         HBMX_STB_CYC       = (HBMX_STB_NS * 1000 + HBMX_CLK_PS - 1) / HBMX_CLK_PS;
  localparam logic [3:0] HBMX_ALE_CNT       = 4'(HBMX_ALE_CYC - 1);
  localparam logic [3:0] HBMX_STB_CNT       = 4'(HBMX_STB_CYC - 1);
  // request word: write flag, address, data
  localparam int         HBMX_RW            = 1 + HBMX_AW + HBMX_DW;
  // access states
  typedef enum logic [1:0]
  {
    HBMX_IDLE = 2'b00,
    HBMX_ADDR = 2'b01,
    HBMX_STRB = 2'b10,
    HBMX_DONE = 2'b11
  } hbmx_state_e;
endpackage : hbmx_pkg
`default_nettype wire

/* verilog/hbmx_port.sv */
`timescale 1ns/100ps
`default_nettype none
module hbmx_port
(
  input  wire logic                        core_clk,
  input  wire logic                        rst_b,
  input  wire logic [hbmx_pkg::HBMX_MAIN_MODE_W-1:0] interface_main_config,
  input  wire logic [1:0]                  host_bus_config,
  input  wire logic [1:0]                  select_line_config,
  input  wire logic                        req_valid,
  output logic                             req_ready,
  input  wire logic                        req_write,
  input  wire logic [hbmx_pkg::HBMX_AW-1:0] req_addr,
  input  wire logic [hbmx_pkg::HBMX_DW-1:0] req_wdata,
  output logic                             rsp_valid,
  output logic [hbmx_pkg::HBMX_DW-1:0]     rsp_rdata,
  output logic [hbmx_pkg::HBMX_DW-1:0]     shared_addr_data_out,
  output logic [hbmx_pkg::HBMX_DW-1:0]     shared_addr_data_oe,
  input  wire logic [hbmx_pkg::HBMX_DW-1:0] shared_addr_data_in,
  output logic [hbmx_pkg::HBMX_AW-1:8]     addr_hi,
  output logic                             ale,
  output logic                             rd_b,
  output logic                             wr_b,
  output logic [3:0]                       sel_b,
  output logic                             enabled
);
  import hbmx_pkg::*;

  ////////////////////////////////////////////////////////////////
  // reset release through two flops
  logic rst_s1;          // first sync stage
  logic rst_n;           // synchronised reset

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // personality decode
  logic active;          // muxed eight-bit host bus in force

  assign active = (interface_main_config == HBMX_MAIN_MODE_HB8)
               && (host_bus_config == HBMX_HB_MODE_MUX);

  // active-high select pattern for a config code and address
  function automatic logic [3:0] sel_decode(input logic [1:0] cfg, input logic [HBMX_AW-1:0] a);
    logic [3:0] s;
    s = 4'h0;
    unique case (cfg)
      HBMX_CS_ALE:     s = 4'h0;                                  // latch strobe only
      HBMX_CS_ONE:     s = 4'h1;                                  // one select
      HBMX_CS_TWO,
      HBMX_CS_ALE_TWO: s = a[HBMX_AW-1] ? 4'h2 : 4'h1;            // top address bit picks
    endcase
    return s;
  endfunction : sel_decode

  ////////////////////////////////////////////////////////////////
  // request buffer: stall downstream loses nothing
  logic              b_valid;
  logic              b_ready;
  logic [HBMX_RW-1:0] b_data;

  hbmx_buf #(.W(HBMX_RW)) u_buf
  (
    .clk       (core_clk),
    .rst_n     (rst_n),
    .in_valid  (req_valid),
    .in_ready  (req_ready),
    .in_data   ({req_write, req_addr, req_wdata}),
    .out_valid (b_valid),
    .out_ready (b_ready),
    .out_data  (b_data)
  );

  ////////////////////////////////////////////////////////////////
  // access sequencer
  hbmx_state_e       state;
  hbmx_state_e       next_state;
  logic [3:0]        cnt;       // phase cycle counter
  logic              cur_wr;    // access is a write
  logic [HBMX_AW-1:0] cur_addr; // latched access address
  logic [HBMX_DW-1:0] cur_data; // write byte

  // take a word only when idle and personality active
  assign b_ready = (state == HBMX_IDLE) && active;

  // next state
  always_comb
  begin
    next_state = state;
    unique case (state)
      HBMX_IDLE: if (b_valid && active) next_state = HBMX_ADDR;
      HBMX_ADDR: if (cnt == HBMX_ALE_CNT) next_state = HBMX_STRB;
      HBMX_STRB: if (cnt == HBMX_STB_CNT) next_state = HBMX_DONE;
      HBMX_DONE: next_state = HBMX_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      state <= HBMX_IDLE;
    else
      state <= next_state;
  end

  // phase counter restarts at each state change
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt <= 4'h0;
    else if (next_state != state)
      cnt <= 4'h0;
    else
      cnt <= 4'(cnt + 4'h1);
  end

  // capture the buffered word at start of access
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur_wr   <= 1'b0;
      cur_addr <= '0;
      cur_data <= '0;
    end
    else if (b_valid && b_ready)
    begin
      cur_wr   <= b_data[HBMX_RW-1];
      cur_addr <= b_data[HBMX_DW +: HBMX_AW];
      cur_data <= b_data[HBMX_DW-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////
  // pin drive; outputs registered from next_state, addr_hi from the buffer handshake
  logic [3:0] sel_n;     // select pattern for this access
  logic       use_ale;   // config includes latch strobe

  // first address-phase cycle takes the word still in the buffer: cur_addr is loaded on that same edge
  assign sel_n   = sel_decode(select_line_config, (state == HBMX_IDLE) ? b_data[HBMX_DW +: HBMX_AW] : cur_addr);
  assign use_ale = (select_line_config == HBMX_CS_ALE) || (select_line_config == HBMX_CS_ALE_TWO);

  // shared lines: address in latch phase, write byte in strobe phase
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shared_addr_data_out <= '0;
      shared_addr_data_oe  <= '0;
    end
    else if (next_state == HBMX_ADDR)
    begin
      shared_addr_data_out <= (state == HBMX_IDLE) ? b_data[HBMX_DW +: HBMX_DW]
                                                   : cur_addr[HBMX_DW-1:0];
      shared_addr_data_oe  <= '1;
    end
    else if (next_state == HBMX_STRB)
    begin
      shared_addr_data_out <= cur_data;
      shared_addr_data_oe  <= cur_wr ? '1 : '0;                                // read releases lines
    end
    else
    begin
      shared_addr_data_out <= '0;
      shared_addr_data_oe  <= '0;
    end
  end

  // dedicated upper address held for the whole access
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      addr_hi <= '0;
    else if (b_valid && b_ready)
      addr_hi <= b_data[HBMX_DW+8 +: HBMX_AW-8];
  end

  // latch strobe high only during address phase, when configured
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      ale <= 1'b0;
    else
      ale <= (next_state == HBMX_ADDR) && use_ale;
  end

  // data strobes, low active, only after latch phase
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_b <= 1'b1;
      wr_b <= 1'b1;
    end
    else
    begin
      rd_b <= !((next_state == HBMX_STRB) && !cur_wr);
      wr_b <= !((next_state == HBMX_STRB) && cur_wr);
    end
  end

  // selects low through the access; none in latch-only config
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      sel_b <= 4'hF;
    else if (next_state == HBMX_STRB || next_state == HBMX_ADDR)
      sel_b <= ~sel_n;
    else
      sel_b <= 4'hF;
  end

  // read byte sampled on the last strobe cycle
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end
    else
    begin
      rsp_valid <= (state == HBMX_STRB) && (next_state == HBMX_DONE);
      if ((state == HBMX_STRB) && (next_state == HBMX_DONE) && !cur_wr)
        rsp_rdata <= shared_addr_data_in;
    end
  end

  // personality status
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      enabled <= 1'b0;
    else
      enabled <= active;
  end
endmodule : hbmx_port
`default_nettype wire
